// ===== hw/prei_pkg.sv
// package for the page request event interrupt block: offsets, field positions, reset values, carriers
// assumes a 32-bit register port with byte offsets and one core clock
package prei_pkg;
  localparam logic [7:0] STATUS_OFS = 8'hdc;
  localparam logic [7:0] CTRL_OFS = 8'he0;
  localparam logic [7:0] DATA_OFS = 8'he4;
  localparam logic [7:0] ADDR_OFS = 8'he8;
  localparam logic [7:0] IRQ_STS_OFS = 8'hf0;
  localparam logic [7:0] IRQ_EN_OFS = 8'hf4;
  localparam int MASK_BIT = 31;
  localparam int PEND_BIT = 30;
  localparam int PPR_BIT = 0;
  localparam int PRO_BIT = 1;
  localparam int ADDR_LSB = 2;
  localparam int LOW_MSB = 15;
  localparam int UP_LSB = 16;
  localparam int IRQ_SENT_BIT = 0;
  localparam int IRQ_OVF_BIT = 1;
  localparam logic MASK_RST = 1'b1;
  localparam logic [31:0] DATA_RST = 32'h0;
  localparam logic [29:0] ADDR_RST = 30'h0;
  localparam logic [1:0] AL_ZERO = 2'h0;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } prei_msg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } prei_bus_t;

  typedef struct packed {
    logic mask;
    logic pend;
    logic queue_entry_pending;
    logic queue_overflow_flag;
    logic [31:0] data;
    logic [29:0] addr;
    logic [1:0] ists;
    logic [1:0] ien;
    logic [31:0] rdata;
    logic seen;
  } prei_state_t;
endpackage : prei_pkg

// ===== hw/prei_event_irq.sv
// page request event interrupt: mask/pending control, status flags and message issue
// assumes queue events and the hold condition come from logic on clk_i; message path takes valid/ready
// Summary of operation
// - mask bit resets to one
// - unmasked condition sends message from data, address
// - no message while mask set
// - new condition sets pending bit
// - queue entry added is a condition
// - queue overflow is a condition
// - flag already set: no new condition
// - pending stays set until message sent or entry flag serviced
// - sending the message clears pending
// - servicing entry flag clears pending, no message
// - low data bits form message data
// - upper data only with 32-bit data
// - no support: page request registers read zero, ignore writes; irq status and enable still work
// - overflow flag cleared by writing one
// - message address is dword aligned register
`timescale 1ns/1ps
module prei_event_irq #(
  parameter bit PRS_SUPPORT = 1'b1,
  parameter bit DATA32 = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic entry_added_i,
  input wire logic overflow_i,
  input wire logic hold_msg_i,
  output logic msg_valid_o,
  input wire logic msg_ready_i,
  output prei_pkg::prei_msg_t msg_o,
  output logic irq_o
);
  prei_pkg::prei_state_t st_r;
  prei_pkg::prei_state_t st_nxt;
  prei_pkg::prei_bus_t bus;
  logic new_cond;
  logic sent;
  logic ppr_svc;
  logic ovf_evt;
  logic wr_ctrl;
  logic wr_data;
  logic wr_addr;
  logic wr_sts;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // any offset that this block answers; everything else reads zero
  function automatic logic known(input logic [7:0] a);
    known = hit(a, prei_pkg::STATUS_OFS) || hit(a, prei_pkg::CTRL_OFS) || hit(a, prei_pkg::DATA_OFS) ||
      hit(a, prei_pkg::ADDR_OFS) || hit(a, prei_pkg::IRQ_STS_OFS) || hit(a, prei_pkg::IRQ_EN_OFS);
  endfunction : known

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  // flags are the registered ones, so a clear in this cycle cannot fake a fresh condition
  assign new_cond = PRS_SUPPORT && (entry_added_i || overflow_i) && !st_r.queue_entry_pending && !st_r.queue_overflow_flag;
  assign ovf_evt = PRS_SUPPORT && overflow_i && !st_r.queue_overflow_flag;
  // message offered only when pending, unmasked and not held back
  assign msg_valid_o = st_r.pend && !st_r.mask && !hold_msg_i;
  assign sent = msg_valid_o && msg_ready_i;
  assign ppr_svc = PRS_SUPPORT && bus.wr && hit(bus.addr, prei_pkg::STATUS_OFS) && bus.wdata[prei_pkg::PPR_BIT];
  assign wr_ctrl = PRS_SUPPORT && bus.wr && hit(bus.addr, prei_pkg::CTRL_OFS);
  assign wr_data = PRS_SUPPORT && bus.wr && hit(bus.addr, prei_pkg::DATA_OFS);
  assign wr_addr = PRS_SUPPORT && bus.wr && hit(bus.addr, prei_pkg::ADDR_OFS);
  assign wr_sts = PRS_SUPPORT && bus.wr && hit(bus.addr, prei_pkg::STATUS_OFS);
  // one driver for the whole message struct
  assign msg_o = '{addr: {st_r.addr, prei_pkg::AL_ZERO}, data: st_r.data};
  assign rdata_o = st_r.rdata;
  assign irq_o = |(st_r.ists & st_r.ien);

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.seen = 1'b1;
    // pending: a fresh condition wins over a send or a service in the same cycle
    if (new_cond)
    begin
      st_nxt.pend = 1'b1;
    end
    else if (sent || ppr_svc)
    begin
      st_nxt.pend = 1'b0;
    end
    else
    begin
      st_nxt.pend = st_r.pend;
    end
    if (PRS_SUPPORT && bus.wr)
    begin
      if (hit(bus.addr, prei_pkg::CTRL_OFS))
      begin
        // only the mask is writable; pending and reserved bits are dropped
        st_nxt.mask = bus.wdata[prei_pkg::MASK_BIT];
      end
      if (hit(bus.addr, prei_pkg::DATA_OFS))
      begin
        st_nxt.data[prei_pkg::LOW_MSB:0] = bus.wdata[prei_pkg::LOW_MSB:0];
        st_nxt.data[31:prei_pkg::UP_LSB] = DATA32 ? bus.wdata[31:prei_pkg::UP_LSB] : 16'h0;
      end
      if (hit(bus.addr, prei_pkg::ADDR_OFS))
      begin
        st_nxt.addr = bus.wdata[31:prei_pkg::ADDR_LSB];
      end
      if (hit(bus.addr, prei_pkg::STATUS_OFS))
      begin
        if (bus.wdata[prei_pkg::PPR_BIT])
        begin
          st_nxt.queue_entry_pending = 1'b0;
        end
        if (bus.wdata[prei_pkg::PRO_BIT])
        begin
          st_nxt.queue_overflow_flag = 1'b0;
        end
      end
    end
    if (bus.wr && hit(bus.addr, prei_pkg::IRQ_STS_OFS))
    begin
      st_nxt.ists = st_r.ists & ~bus.wdata[1:0];
    end
    if (bus.wr && hit(bus.addr, prei_pkg::IRQ_EN_OFS))
    begin
      st_nxt.ien = bus.wdata[1:0];
    end
    // hardware sets beat software clears, except a repeated overflow while the flag is set, where the clear wins
    if (PRS_SUPPORT && entry_added_i)
    begin
      st_nxt.queue_entry_pending = 1'b1;
    end
    if (ovf_evt)
    begin
      st_nxt.queue_overflow_flag = 1'b1;
      st_nxt.ists[prei_pkg::IRQ_OVF_BIT] = 1'b1;
    end
    if (sent)
    begin
      st_nxt.ists[prei_pkg::IRQ_SENT_BIT] = 1'b1;
    end
    st_nxt.rdata = 32'h0;
    if (bus.rd)
    begin
      // without page request support all but the irq status and enable registers read as zero
      if (PRS_SUPPORT && hit(bus.addr, prei_pkg::CTRL_OFS))
      begin
        st_nxt.rdata[prei_pkg::MASK_BIT] = st_r.mask;
        st_nxt.rdata[prei_pkg::PEND_BIT] = st_r.pend;
      end
      else if (PRS_SUPPORT && hit(bus.addr, prei_pkg::DATA_OFS))
      begin
        st_nxt.rdata = st_r.data;
      end
      else if (PRS_SUPPORT && hit(bus.addr, prei_pkg::ADDR_OFS))
      begin
        st_nxt.rdata = {st_r.addr, prei_pkg::AL_ZERO};
      end
      else if (PRS_SUPPORT && hit(bus.addr, prei_pkg::STATUS_OFS))
      begin
        st_nxt.rdata[prei_pkg::PPR_BIT] = st_r.queue_entry_pending;
        st_nxt.rdata[prei_pkg::PRO_BIT] = st_r.queue_overflow_flag;
      end
      else if (hit(bus.addr, prei_pkg::IRQ_STS_OFS))
      begin
        st_nxt.rdata[1:0] = st_r.ists;
      end
      else if (hit(bus.addr, prei_pkg::IRQ_EN_OFS))
      begin
        st_nxt.rdata[1:0] = st_r.ien;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r <= '0;
      st_r.mask <= prei_pkg::MASK_RST;
      st_r.data <= prei_pkg::DATA_RST;
      st_r.addr <= prei_pkg::ADDR_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_send;
    msg_valid_o && msg_ready_i && !new_cond;
  endsequence
  sequence s_ppr_svc;
    ppr_svc && !new_cond && !sent;
  endsequence
  sequence s_ctrl_wr;
    PRS_SUPPORT && wr_i && addr_i == prei_pkg::CTRL_OFS;
  endsequence

  mask_reset_a: assert property (!st_r.seen |-> st_r.mask)
    else $error("mask not set after reset");
  send_unmasked_a: assert property (st_r.pend && !st_r.mask && !hold_msg_i |-> msg_valid_o)
    else $error("unmasked pending message not offered");
  mask_blocks_a: assert property (st_r.mask |-> !msg_valid_o)
    else $error("message offered while masked");
  pend_set_a: assert property (new_cond |=> st_r.pend)
    else $error("pending not set on new condition");
  entry_cond_a: assert property (PRS_SUPPORT && entry_added_i && !st_r.queue_entry_pending && !st_r.queue_overflow_flag |=> st_r.queue_entry_pending && st_r.pend)
    else $error("queue entry did not raise condition");
  ovf_cond_a: assert property (PRS_SUPPORT && overflow_i && !st_r.queue_entry_pending && !st_r.queue_overflow_flag |=> st_r.queue_overflow_flag && st_r.pend)
    else $error("overflow did not raise condition");
  no_new_a: assert property ((st_r.queue_entry_pending || st_r.queue_overflow_flag) && !st_r.pend |=> !st_r.pend)
    else $error("pending set with flag already set");
  pend_hold_a: assert property (st_r.pend && !sent && !ppr_svc |=> st_r.pend)
    else $error("pending dropped before message sent");
  send_clear_a: assert property (s_send |=> !st_r.pend)
    else $error("pending not cleared after send");
  svc_clear_a: assert property (s_ppr_svc |=> !st_r.pend && !msg_valid_o)
    else $error("pending not cleared on entry service");
  data_low_a: assert property (msg_valid_o |-> msg_o.data[15:0] == st_r.data[15:0])
    else $error("message data low bits wrong");
  data_up_a: assert property (!DATA32 |-> msg_o.data[31:16] == 16'h0)
    else $error("upper data present without 32-bit support");
  no_support_a: assert property (!PRS_SUPPORT && rd_i && addr_i == prei_pkg::CTRL_OFS |=> rdata_o == 32'h0 && !msg_valid_o)
    else $error("unsupported block not reading zero");
  ovf_keep_a: assert property (PRS_SUPPORT && wr_i && addr_i == prei_pkg::STATUS_OFS && !wdata_i[1] && st_r.queue_overflow_flag |=> st_r.queue_overflow_flag)
    else $error("overflow flag lost on zero write");
  ovf_clr_a: assert property (PRS_SUPPORT && wr_i && addr_i == prei_pkg::STATUS_OFS && wdata_i[1] && !overflow_i |=> !st_r.queue_overflow_flag)
    else $error("overflow flag not cleared by one");
  addr_align_a: assert property (msg_valid_o |-> msg_o.addr[1:0] == 2'h0 && msg_o.addr[31:2] == st_r.addr)
    else $error("message address misformed");
  ctrl_wr_a: assert property (s_ctrl_wr |=> st_r.mask == $past(wdata_i[31]) && $stable(st_r.data))
    else $error("control write misapplied");

  sequence s_fresh;
    new_cond && !st_r.mask && !wr_ctrl;
  endsequence
  sequence s_free;
    !hold_msg_i;
  endsequence
  sequence s_unmask_wr;
    wr_ctrl && !wdata_i[prei_pkg::MASK_BIT] && st_r.pend && !ppr_svc && !sent;
  endsequence

  fresh_send_a: assert property (s_fresh ##1 s_free |-> msg_valid_o)
    else $error("fresh unmasked condition not offered");
  masked_cond_a: assert property (new_cond && st_r.mask && !wr_ctrl |=> st_r.pend && !msg_valid_o)
    else $error("masked condition offered");
  pend_quiet_a: assert property (!st_r.pend && !new_cond |=> !st_r.pend)
    else $error("pending set without condition");
  entry_set_a: assert property (PRS_SUPPORT && entry_added_i |=> st_r.queue_entry_pending)
    else $error("entry flag not set");
  ppr_hold_a: assert property (st_r.queue_entry_pending && !(wr_sts && wdata_i[prei_pkg::PPR_BIT]) |=> st_r.queue_entry_pending)
    else $error("entry flag lost");
  ovf_set_a: assert property (PRS_SUPPORT && overflow_i && !st_r.queue_overflow_flag |=> st_r.queue_overflow_flag)
    else $error("overflow flag not set");
  ovf_sts_a: assert property (ovf_evt |=> st_r.ists[prei_pkg::IRQ_OVF_BIT])
    else $error("overflow event not recorded");
  flag_block_a: assert property (st_r.queue_entry_pending || st_r.queue_overflow_flag |-> !new_cond)
    else $error("condition taken with flag set");
  hold_blocks_a: assert property (hold_msg_i |-> !msg_valid_o)
    else $error("message offered while held");
  valid_pend_a: assert property (msg_valid_o |-> st_r.pend)
    else $error("message offered without pending");
  masked_keep_a: assert property (st_r.pend && st_r.mask && !ppr_svc |=> st_r.pend)
    else $error("masked pending dropped");
  msg_stable_a: assert property (msg_valid_o && !msg_ready_i && !wr_i |=> $stable(msg_o))
    else $error("offered message changed");
  unmask_a: assert property (s_unmask_wr |=> st_r.pend && !st_r.mask)
    else $error("unmask lost pending message");
  sent_sts_a: assert property (sent |=> st_r.ists[prei_pkg::IRQ_SENT_BIT])
    else $error("send not recorded");
  sts_w1c_a: assert property (wr_i && addr_i == prei_pkg::IRQ_STS_OFS && wdata_i[prei_pkg::IRQ_SENT_BIT] && !sent
    |=> !st_r.ists[prei_pkg::IRQ_SENT_BIT])
    else $error("send status not cleared");
  ppr_clr_a: assert property (wr_sts && wdata_i[prei_pkg::PPR_BIT] && !entry_added_i |=> !st_r.queue_entry_pending)
    else $error("entry flag not cleared");
  data_write_a: assert property (wr_data |=> st_r.data[prei_pkg::LOW_MSB:0] == $past(wdata_i[prei_pkg::LOW_MSB:0]))
    else $error("data write lost");
  data_read_a: assert property (PRS_SUPPORT && rd_i && addr_i == prei_pkg::DATA_OFS |=> rdata_o == $past(st_r.data))
    else $error("data read wrong");
  data16_a: assert property (!DATA32 |-> st_r.data[31:prei_pkg::UP_LSB] == 16'h0)
    else $error("upper data stored without 32-bit support");
  nosup_a: assert property (!PRS_SUPPORT |-> !st_r.pend && st_r.mask && st_r.data == prei_pkg::DATA_RST)
    else $error("unsupported block changed state");
  unmapped_rd_a: assert property (rd_i && !known(addr_i) |=> rdata_o == 32'h0)
    else $error("unmapped offset not zero");
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data without read");
  pro_hold_a: assert property (st_r.queue_overflow_flag && !(wr_sts && wdata_i[prei_pkg::PRO_BIT]) |=> st_r.queue_overflow_flag)
    else $error("overflow flag lost");
  sts_read_a: assert property (PRS_SUPPORT && rd_i && addr_i == prei_pkg::STATUS_OFS
    |=> rdata_o == {30'h0, $past(st_r.queue_overflow_flag), $past(st_r.queue_entry_pending)})
    else $error("status read wrong");
  addr_write_a: assert property (wr_addr |=> st_r.addr == $past(wdata_i[31:prei_pkg::ADDR_LSB]))
    else $error("address write lost");
  ctrl_read_a: assert property (PRS_SUPPORT && rd_i && addr_i == prei_pkg::CTRL_OFS
    |=> rdata_o == {$past(st_r.mask), $past(st_r.pend), 30'h0})
    else $error("control read wrong");
  pend_ro_a: assert property (wr_ctrl && !new_cond && !sent && !ppr_svc |=> st_r.pend == $past(st_r.pend))
    else $error("pending written by software");
  mask_keep_a: assert property (!wr_ctrl |=> $stable(st_r.mask))
    else $error("mask changed without write");
  ien_write_a: assert property (wr_i && addr_i == prei_pkg::IRQ_EN_OFS |=> st_r.ien == $past(wdata_i[1:0]))
    else $error("irq enable write lost");
  irq_quiet_a: assert property (st_r.ien == 2'h0 |-> !irq_o)
    else $error("irq raised with nothing enabled");
endmodule : prei_event_irq

// ===== verif/prei_sink.sv
// message path model: takes offered interrupt messages, counts them, keeps the last one
// assumes a valid/ready handshake on clk_i; stall_i models a slow path
`timescale 1ns/1ps
module prei_sink (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic valid_i,
  input prei_pkg::prei_msg_t msg_i,
  input wire logic stall_i,
  output logic ready_o,
  output logic [7:0] count_o,
  output prei_pkg::prei_msg_t last_o
);
  // a stalled path holds ready low, so the device has to keep offering
  assign ready_o = valid_i & !stall_i;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count_o <= 8'h0;
      last_o <= '0;
    end
    else if (valid_i && ready_o)
    begin
      count_o <= count_o + 8'h1;
      last_o <= msg_i;
    end
  end
endmodule : prei_sink

// ===== verif/tb_top.sv
// bench for the page request event interrupt block
// assumes the register port and message path of prei_event_irq; a second copy lacks queue support
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic entry_added_i = 1'b0;
  logic overflow_i = 1'b0;
  logic hold_msg_i = 1'b0;
  logic stall = 1'b0;
  logic [31:0] rdata_o, rdata2, rdata3, rv, rv2, rv3;
  logic msg_valid_o, msg_ready_i, irq_o;
  logic [7:0] cnt;
  prei_pkg::prei_msg_t msg_o, last;
  int mismatches = 0;
  int n_tests = 0;
  always #4 clk_i = ~clk_i;
  prei_event_irq prei_event_irq_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .entry_added_i(entry_added_i), .overflow_i(overflow_i), .hold_msg_i(hold_msg_i),
    .msg_valid_o(msg_valid_o), .msg_ready_i(msg_ready_i), .msg_o(msg_o), .irq_o(irq_o));
  // no queue support: register port only, message side left idle
  prei_event_irq #(.PRS_SUPPORT(1'b0)) prei_event_irq_nosup_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata2), .entry_added_i(entry_added_i),
    .overflow_i(overflow_i), .hold_msg_i(hold_msg_i), .msg_valid_o(), .msg_ready_i(1'b0), .msg_o(), .irq_o());
  // 16-bit message data only: register port watched, message side left idle
  prei_event_irq #(.DATA32(1'b0)) prei_event_irq_d16_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata3), .entry_added_i(entry_added_i),
    .overflow_i(overflow_i), .hold_msg_i(hold_msg_i), .msg_valid_o(), .msg_ready_i(1'b0), .msg_o(), .irq_o());
  prei_sink prei_sink_i (.clk_i(clk_i), .rst_i(rst_i), .valid_i(msg_valid_o), .msg_i(msg_o), .stall_i(stall),
    .ready_o(msg_ready_i), .count_o(cnt), .last_o(last));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    rv = rdata_o;
    rv2 = rdata2;
    rv3 = rdata3;
  endtask : rd
  task ev(input logic e, input logic o);
    @(posedge clk_i);
    entry_added_i <= e;
    overflow_i <= o;
    @(posedge clk_i);
    entry_added_i <= 1'b0;
    overflow_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : ev
  task summarize;
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  initial
  begin
    #200000;
    mismatches++;
    summarize;
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(prei_pkg::CTRL_OFS);
    chk("ctrl", rv, 32'h8000_0000);
    chk("ctrl nosup", rv2, 32'h0);
    wr(prei_pkg::DATA_OFS, 32'h1234_abcd);
    wr(prei_pkg::ADDR_OFS, 32'h0000_1003);
    wr(prei_pkg::IRQ_EN_OFS, 32'h3);
    rd(prei_pkg::DATA_OFS);
    chk("data", rv, 32'h1234_abcd);
    chk("data nosup", rv2, 32'h0);
    chk("data 16bit", rv3, 32'h0000_abcd);
    ev(1'b1, 1'b0);
    chk("valid", 32'(msg_valid_o), 32'h0);
    rd(prei_pkg::CTRL_OFS);
    chk("ctrl", rv, 32'hc000_0000);
    rd(prei_pkg::STATUS_OFS);
    chk("status", rv, 32'h1);
    wr(prei_pkg::CTRL_OFS, 32'h0);
    rd(prei_pkg::CTRL_OFS);
    chk("ctrl", rv, 32'h0);
    chk("count", 32'(cnt), 32'h1);
    chk("addr", last.addr, 32'h0000_1000);
    chk("msg data", last.data, 32'h1234_abcd);
    chk("irq", 32'(irq_o), 32'h1);
    wr(prei_pkg::IRQ_STS_OFS, 32'h3);
    ev(1'b1, 1'b0);
    chk("count", 32'(cnt), 32'h1);
    chk("irq", 32'(irq_o), 32'h0);
    wr(prei_pkg::STATUS_OFS, 32'h1);
    wr(prei_pkg::CTRL_OFS, 32'h8000_0000);
    ev(1'b1, 1'b0);
    wr(prei_pkg::STATUS_OFS, 32'h1);
    rd(prei_pkg::CTRL_OFS);
    chk("ctrl", rv, 32'h8000_0000);
    wr(prei_pkg::CTRL_OFS, 32'h0);
    ev(1'b0, 1'b0);
    chk("count", 32'(cnt), 32'h1);
    // slow path: message must stay offered until taken
    stall <= 1'b1;
    ev(1'b0, 1'b1);
    chk("valid", 32'(msg_valid_o), 32'h1);
    rd(prei_pkg::STATUS_OFS);
    chk("status", rv, 32'h2);
    stall <= 1'b0;
    ev(1'b0, 1'b0);
    chk("count", 32'(cnt), 32'h2);
    chk("irq ovf", 32'(irq_o), 32'h1);
    rd(prei_pkg::IRQ_STS_OFS);
    chk("irq status", rv, 32'h3);
    wr(prei_pkg::STATUS_OFS, 32'h0);
    rd(prei_pkg::STATUS_OFS);
    chk("status", rv, 32'h2);
    wr(prei_pkg::STATUS_OFS, 32'h2);
    rd(prei_pkg::STATUS_OFS);
    chk("status", rv, 32'h0);
    hold_msg_i <= 1'b1;
    ev(1'b1, 1'b0);
    chk("valid", 32'(msg_valid_o), 32'h0);
    rd(prei_pkg::CTRL_OFS);
    chk("ctrl", rv, 32'h4000_0000);
    hold_msg_i <= 1'b0;
    ev(1'b0, 1'b0);
    chk("count", 32'(cnt), 32'h3);
    wr(prei_pkg::CTRL_OFS, 32'h7fff_ffff);
    rd(prei_pkg::CTRL_OFS);
    chk("ctrl", rv, 32'h0);
    rd(8'h40);
    chk("unmapped", rv, 32'h0);
    summarize;
  end
endmodule : tb_top
